/* logic/npg_pkg.sv */
// Shared constants for the nested interrupt priority gate.
// Assumes an 8-bit register port and one core clock domain.
package npg_pkg;

  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned LVL_W        = 2;
  localparam int unsigned HIST_DEPTH   = 4;
  localparam int unsigned DEPTH_W      = 3;
  localparam int unsigned SRC_PER_REG  = 4;
  localparam int unsigned DEF_NUM_SRC  = 16;
  localparam int unsigned DEF_IDX_W    = 4;
  localparam int unsigned RST_SRC_N    = 8;
  localparam int unsigned RST_EN_N     = 4;

  // Register offsets.
  localparam logic [7:0] CSR_ADDR       = 8'h00;
  localparam logic [7:0] LVL_BASE_ADDR  = 8'h01;
  localparam logic [7:0] RST_EN_ADDR    = 8'h10;
  localparam logic [7:0] RST_CAUSE_ADDR = 8'h11;

  // Control and status register fields.
  localparam int unsigned CSR_MASK_LSB  = 0;
  localparam int unsigned CSR_POP_BIT   = 2;
  localparam int unsigned CSR_FULL_BIT  = 3;
  localparam int unsigned CSR_EMPTY_BIT = 4;
  localparam int unsigned CSR_EN_BIT    = 7;

  // Reset enable bits.
  localparam int unsigned RE_WDOG = 0;
  localparam int unsigned RE_LVD  = 1;
  localparam int unsigned RE_PIN  = 2;
  localparam int unsigned RE_CLK  = 3;

  // Reset cause bits.
  localparam int unsigned RC_WDOG = 0;
  localparam int unsigned RC_LVD  = 1;
  localparam int unsigned RC_PIN  = 2;
  localparam int unsigned RC_OPC  = 3;
  localparam int unsigned RC_ADR  = 4;
  localparam int unsigned RC_POR  = 5;
  localparam int unsigned RC_CLK  = 6;
  localparam int unsigned RC_DBG  = 7;

  // Reset values and fixed figures.
  localparam logic [1:0]  MASK_RST       = 2'h0;
  localparam logic [1:0]  LVL_RST        = 2'h0;
  localparam logic [1:0]  DEEP_STOP_MASK = 2'h0;
  localparam logic [3:0]  RST_EN_RST     = 4'h0;
  localparam logic [7:0]  CAUSE_RST      = 8'h00;
  localparam logic [2:0]  DEPTH_FULL     = 3'h4;
  localparam logic [2:0]  DEPTH_EMPTY    = 3'h0;
  localparam logic [15:0] RESET_VECTOR   = 16'hFFFE;

endpackage : npg_pkg

/* logic/npg_reset_collect.sv */
// Collects the sources that share the reset vector into one request.
// Assumes all source events are synchronous one-cycle or level flags.
`timescale 1ns/1ps
module npg_reset_collect (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic [npg_pkg::RST_SRC_N-1:0]  src_evt,
  input  wire logic [npg_pkg::RST_EN_N-1:0]   rst_en,
  output logic                                reset_request,
  output logic [npg_pkg::RST_SRC_N-1:0]       reset_cause
);
  import npg_pkg::*;

  typedef struct packed {
    logic                 req;
    logic [RST_SRC_N-1:0] cause;
  } npg_rc_state_t;

  npg_rc_state_t        q;
  npg_rc_state_t        d;
  logic [RST_SRC_N-1:0] allow;
  logic [RST_SRC_N-1:0] hit;

  always_comb begin
    allow          = '1;
    allow[RC_WDOG] = rst_en[RE_WDOG];
    allow[RC_LVD]  = rst_en[RE_LVD];
    allow[RC_PIN]  = rst_en[RE_PIN];
    allow[RC_CLK]  = rst_en[RE_CLK];
    hit            = src_evt & allow;
    d              = q;
    d.req          = |hit;
    // The cause stays until the next request so software can read it.
    if (|hit) begin
      d.cause = hit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q.req   <= 1'b0;
      q.cause <= CAUSE_RST;
    end else begin
      q <= d;
    end
  end

  assign reset_request = q.req;
  assign reset_cause   = q.cause;

endmodule : npg_reset_collect

/* logic/npg_gate.sv */
// Interrupt priority gate with mask history stack and register port.
// Assumes synchronous source requests and a one-cycle vector fetch strobe.
// Function
// - Up to four nested priority levels let higher requests interrupt handlers.
// - Each source has its own 2-bit programmable priority level.
// - Level 3 is most urgent, level 0 least urgent.
// - Software may read and write level fields at any time.
// - When enabled, each request compares its level with the 2-bit mask.
// - A source passes only when its level is at least the mask.
// - In deep stop the comparison uses mask zero.
// - When disabled, requests pass straight through ungated.
// - Lower-level requests are held off during a higher-level handler.
// - Requests at or above the serviced level may preempt.
// - Vector fetch loads the mask with the serviced source level.
// - The mask stays software-writable in main flow and handlers.
// - Each vector fetch saves the prior mask, four values deep.
// - Several sources share the single reset vector request.
// - Watchdog, low-voltage, pin and clock resets have enable bits.
// - The mask sits in the two low bits of the control register.
// - Saved masks shift into a four-entry pseudo stack.
// - Writing one to the pop bit restores the newest saved mask.
// - Full flag when last position written, empty when all popped.
`timescale 1ns/1ps
module npg_gate #(
  parameter int unsigned NUM_SRC = npg_pkg::DEF_NUM_SRC,
  parameter int unsigned IDX_W   = npg_pkg::DEF_IDX_W
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic [npg_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [npg_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [npg_pkg::DATA_W-1:0]          reg_rdata,
  input  wire logic [NUM_SRC-1:0]             src_req,
  input  wire logic                           deep_stop_mode,
  input  wire logic                           vec_fetch,
  input  wire logic [IDX_W-1:0]               vec_src,
  output logic [NUM_SRC-1:0]                  gated_request_out,
  input  wire logic [npg_pkg::RST_SRC_N-1:0]  reset_evt,
  output logic                                reset_request,
  output logic [15:0]                         reset_vector
);
  import npg_pkg::*;

  localparam int unsigned NUM_LVL_REGS =
    (NUM_SRC + SRC_PER_REG - 1) / SRC_PER_REG;

  typedef struct packed {
    logic                           en;
    logic [LVL_W-1:0]               mask;
    logic [HIST_DEPTH-1:0][LVL_W-1:0] hist;
    logic [DEPTH_W-1:0]             depth;
    logic [NUM_SRC-1:0][LVL_W-1:0]  lvl;
    logic [RST_EN_N-1:0]            rst_en;
    logic [DATA_W-1:0]              rdata;
  } npg_gate_state_t;

  npg_gate_state_t       q;
  npg_gate_state_t       d;
  logic [RST_SRC_N-1:0]  cause;
  logic [LVL_W-1:0]      eff_mask;
  logic                  hist_full;
  logic                  hist_empty;
  logic                  in_lvl_rng;
  logic [ADDR_W-1:0]     lvl_idx;
  logic                  pop_req;

  assign hist_full  = (q.depth == DEPTH_FULL);
  assign hist_empty = (q.depth == DEPTH_EMPTY);

  always_comb begin
    in_lvl_rng = (reg_addr >= LVL_BASE_ADDR) &&
                 (reg_addr < LVL_BASE_ADDR + ADDR_W'(NUM_LVL_REGS));
    lvl_idx    = reg_addr - LVL_BASE_ADDR;
  end

  // Priority comparison and pass-through.
  always_comb begin
    eff_mask = deep_stop_mode ? DEEP_STOP_MASK : q.mask;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (q.en) begin
        // Unsigned compare: 3 beats 0, equal level is allowed through.
        gated_request_out[i] = src_req[i] &&
                               (q.lvl[i] >= eff_mask);
      end else begin
        gated_request_out[i] = src_req[i];
      end
    end
  end

  always_comb begin
    d       = q;
    d.rdata = '0;
    pop_req = 1'b0;

    // Register reads, answered in the following cycle.
    if (reg_rd) begin
      if (reg_addr == CSR_ADDR) begin
        d.rdata[CSR_MASK_LSB +: LVL_W] = q.mask;
        d.rdata[CSR_FULL_BIT]          = hist_full;
        d.rdata[CSR_EMPTY_BIT]         = hist_empty;
        d.rdata[CSR_EN_BIT]            = q.en;
      end else if (in_lvl_rng) begin
        for (int k = 0; k < SRC_PER_REG; k++) begin
          if (int'(lvl_idx) * SRC_PER_REG + k < NUM_SRC) begin
            d.rdata[k*LVL_W +: LVL_W] =
              q.lvl[int'(lvl_idx) * SRC_PER_REG + k];
          end
        end
      end else if (reg_addr == RST_EN_ADDR) begin
        d.rdata[RST_EN_N-1:0] = q.rst_en;
      end else if (reg_addr == RST_CAUSE_ADDR) begin
        d.rdata = cause;
      end
    end

    // Register writes.
    if (reg_wr) begin
      if (reg_addr == CSR_ADDR) begin
        d.en = reg_wdata[CSR_EN_BIT];
        if (reg_wdata[CSR_POP_BIT]) begin
          pop_req = 1'b1;
        end else begin
          d.mask = reg_wdata[CSR_MASK_LSB +: LVL_W];
        end
      end else if (in_lvl_rng) begin
        for (int k = 0; k < SRC_PER_REG; k++) begin
          if (int'(lvl_idx) * SRC_PER_REG + k < NUM_SRC) begin
            d.lvl[int'(lvl_idx) * SRC_PER_REG + k] =
              reg_wdata[k*LVL_W +: LVL_W];
          end
        end
      end else if (reg_addr == RST_EN_ADDR) begin
        d.rst_en = reg_wdata[RST_EN_N-1:0];
      end
    end

    // A pop with nothing stored is ignored so the mask is not corrupted.
    if (pop_req && !hist_empty) begin
      d.mask  = q.hist[0];
      d.hist  = {LVL_RST, q.hist[HIST_DEPTH-1:1]};
      d.depth = q.depth - DEPTH_W'(1);
    end

    // Vector fetch takes precedence over a same-cycle software mask write or pop.
    if (vec_fetch && (int'(vec_src) < NUM_SRC)) begin
      d.mask = q.lvl[vec_src];
      d.hist = {q.hist[HIST_DEPTH-2:0], q.mask};
      // Past four levels the oldest saved mask is lost; full stays set.
      // A same-cycle pop must not lower the depth that the push keeps.
      if (!hist_full) begin
        d.depth = q.depth + DEPTH_W'(1);
      end else begin
        d.depth = q.depth;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q.en     <= 1'b0;
      q.mask   <= MASK_RST;
      q.hist   <= '0;
      q.depth  <= DEPTH_EMPTY;
      q.lvl    <= '0;
      q.rst_en <= RST_EN_RST;
      q.rdata  <= '0;
    end else begin
      q <= d;
    end
  end

  npg_reset_collect u_reset_collect (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .src_evt       (reset_evt),
    .rst_en        (q.rst_en),
    .reset_request (reset_request),
    .reset_cause   (cause)
  );

  assign reg_rdata    = q.rdata;
  assign reset_vector = RESET_VECTOR;

endmodule : npg_gate

/* test/npg_cpu_model.sv */
// Processor side: turns a go request into one vector fetch pulse.
// Assumes gated requests settle before the clock edge that samples go.
`timescale 1ns/1ps
module npg_cpu_model #(
  parameter int unsigned NUM_SRC = 16,
  parameter int unsigned IDX_W   = 4
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [NUM_SRC-1:0] gated_request_out,
  input  wire logic               go,
  output logic                    vec_fetch,
  output logic [IDX_W-1:0]        vec_src
);
  // The highest index wins; programmed levels play no part here.
  always_ff @(posedge core_clk) begin
    vec_fetch <= 1'b0;
    if (!rst_n) begin
      vec_src <= '0;
    end else if (go && |gated_request_out) begin
      vec_fetch <= 1'b1;
      for (int i = 0; i < NUM_SRC; i++) begin
        if (gated_request_out[i]) vec_src <= IDX_W'(i);
      end
    end
  end
endmodule : npg_cpu_model

/* test/npg_gate_chk.sv */
// Port-level checks of the priority gate.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module npg_gate_chk
  import npg_pkg::*;
#(
  parameter int unsigned NUM_SRC = 16,
  parameter int unsigned IDX_W   = 4
) (
  input wire logic                           core_clk,
  input wire logic                           rst_n,
  input wire logic [npg_pkg::ADDR_W-1:0]     reg_addr,
  input wire logic [npg_pkg::DATA_W-1:0]     reg_wdata,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [npg_pkg::DATA_W-1:0]     reg_rdata,
  input wire logic [NUM_SRC-1:0]             src_req,
  input wire logic                           deep_stop_mode,
  input wire logic                           vec_fetch,
  input wire logic [IDX_W-1:0]               vec_src,
  input wire logic [NUM_SRC-1:0]             gated_request_out,
  input wire logic [npg_pkg::RST_SRC_N-1:0]  reset_evt,
  input wire logic                           reset_request,
  input wire logic [15:0]                    reset_vector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rst_passes: assert property ($rose(rst_n)
    |-> gated_request_out == src_req)
    else $error("gate not open after reset");
  a_gate_subset: assert property ((gated_request_out & ~src_req) == '0)
    else $error("output without request");
  a_stop_passes: assert property (deep_stop_mode
    |-> gated_request_out == src_req)
    else $error("deep stop blocked a request");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");
  a_vector_fixed: assert property (reset_vector == RESET_VECTOR)
    else $error("reset vector wrong");
  a_fixed_reset: assert property (
    (reset_evt[RC_OPC] || reset_evt[RC_ADR]
    || reset_evt[RC_POR] || reset_evt[RC_DBG]) |=> reset_request)
    else $error("unqualified reset lost");
  a_quiet_reset: assert property (reset_evt == '0 |=> !reset_request)
    else $error("reset request without event");
  a_gate_holds: assert property (
    !vec_fetch && !reg_wr && !deep_stop_mode ##1
    $stable(src_req) && !deep_stop_mode |-> $stable(gated_request_out))
    else $error("gating changed without cause");
  c_fetch: cover property (vec_fetch);
  c_stop: cover property (deep_stop_mode && |src_req);
  c_reset: cover property (reset_request);
endmodule : npg_gate_chk

bind npg_gate npg_gate_chk #(.NUM_SRC(NUM_SRC), .IDX_W(IDX_W)) chk_u (.*);

/* test/nested_interrupt_priority_gate_tb.sv */
// Self-checking bench of the priority gate with a processor model.
// Assumes the register map and timing of the design hand-over.
`timescale 1ns/1ps
module nested_interrupt_priority_gate_tb;
  import npg_pkg::*;
  typedef struct {logic [7:0] csr; logic dp; logic [15:0] s, e;} npg_row_t;
  logic core_clk, rst_n, reg_wr, reg_rd, deep_stop_mode, vec_fetch, go;
  logic reset_request;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, reset_evt;
  logic [15:0] src_req, gated_request_out, reset_vector;
  logic [3:0]  vec_src;
  int mismatches, n_checks;
  npg_row_t rows[7] = '{'{8'h80,1'b0,16'hFFFF,16'hFFFF},
    '{8'h81,1'b0,16'hFFFF,16'hEEEE}, '{8'h82,1'b0,16'hFFFF,16'hCCCC},
    '{8'h83,1'b0,16'hFFFF,16'h8888}, '{8'h83,1'b1,16'hFFFF,16'hFFFF},
    '{8'h03,1'b0,16'hFFFF,16'hFFFF}, '{8'h83,1'b0,16'h00F0,16'h0080}};
  npg_gate dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_req(src_req),
    .deep_stop_mode(deep_stop_mode), .vec_fetch(vec_fetch),
    .vec_src(vec_src), .gated_request_out(gated_request_out),
    .reset_evt(reset_evt), .reset_request(reset_request),
    .reset_vector(reset_vector));
  npg_cpu_model cpu_u (.core_clk(core_clk), .rst_n(rst_n),
    .gated_request_out(gated_request_out), .go(go),
    .vec_fetch(vec_fetch), .vec_src(vec_src));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask : rd
  task automatic fetch(input logic [15:0] s);
    @(posedge core_clk);
    src_req <= s;
    go      <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : fetch
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #(100 * 2000);
    mismatches++;
    summarize();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, deep_stop_mode, go} = '0;
    {reg_addr, reg_wdata, reset_evt} = '0;
    src_req = 16'h00FF;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CSR_ADDR, 8'h10);
    for (int i = 1; i <= 4; i++) wr(8'(i), 8'hE4);
    rd(8'h03, 8'hE4);
    rd(8'h20, 8'h00);
    foreach (rows[i]) begin
      src_req <= rows[i].s;
      deep_stop_mode <= rows[i].dp;
      wr(CSR_ADDR, rows[i].csr);
      chk(gated_request_out, rows[i].e);
    end
    deep_stop_mode <= 1'b0;
    wr(CSR_ADDR, 8'h80);
    fetch(16'h0081);
    chk(16'(vec_src), 16'h7);
    wr(CSR_ADDR, 8'h80);
    fetch(16'h0002);
    fetch(16'h0004);
    fetch(16'h0008);
    fetch(16'h0080);
    rd(CSR_ADDR, 8'h8B);
    src_req <= 16'hFFFF;
    @(posedge core_clk);
    #1;
    chk(gated_request_out, 16'h8888);
    for (int i = 3; i >= 0; i--) begin
      wr(CSR_ADDR, 8'h84);
      rd(CSR_ADDR, 8'(8'h80 | i | (i == 0 ? 8'h10 : 8'h00)));
    end
    chk(gated_request_out, 16'hFFFF);
    for (int en = 0; en < 2; en++) begin
      wr(RST_EN_ADDR, en ? 8'h0F : 8'h00);
      for (int b = 0; b < 8; b++) begin
        @(posedge core_clk);
        reset_evt <= 8'h01 << b;
        @(posedge core_clk);
        reset_evt <= 8'h00;
        #1;
        chk(16'(reset_request), 16'(en == 1 || b == 3 || b == 4
          || b == 5 || b == 7));
      end
    end
    rd(RST_CAUSE_ADDR, 8'h80);
    rd(RST_EN_ADDR, 8'h0F);
    // A pop with an empty history must leave the written mask alone.
    wr(CSR_ADDR, 8'h82);
    wr(CSR_ADDR, 8'h84);
    rd(CSR_ADDR, 8'h92);
    // Reset again in mid-run, with every register but the empty history stack away from its reset value.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(gated_request_out, 16'hFFFF);
    rd(CSR_ADDR, 8'h10);
    rd(8'h01, 8'h00);
    rd(RST_EN_ADDR, 8'h00);
    rd(RST_CAUSE_ADDR, 8'h00);
    chk(reset_vector, 16'hFFFE);
    summarize();
  end
endmodule : nested_interrupt_priority_gate_tb
